//--- core/uhc_host_ctrl.sv
/*
  usb otg host control, address, token, frame threshold and config
  registers behind an axi4-lite slave, with token and frame sequencing.
  assumes bus lines and comparator pins are asynchronous, cpu_idle_i is
  on mclk_i, and the bus master keeps one read and one write in flight.
*/
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "uhc_defs.svh"
module uhc_host_ctrl
  import uhc_pkg::*;
#(
  parameter int FRAME_CYC = `UHC_FRAME_CYC
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic dp_i,
  input wire logic dm_i,
  input wire logic bus_power_valid_pin_i,
  input wire logic session_valid_pin_i,
  input wire logic session_end_pin_i,
  input wire logic comparator_status_pin_a_i,
  input wire logic comparator_status_pin_b_i,
  input wire logic [2:0] onchip_cmp_i,
  input wire logic cpu_idle_i,
  output logic module_run_o,
  output logic host_mode_o,
  output logic line_pulldown_o,
  output logic bus_reset_drive_o,
  output logic resume_drive_o,
  output logic pingpong_pointer_clear_o,
  output logic [1:0] pingpong_config_o,
  output logic frame_marker_o,
  output logic token_start_o,
  output logic [3:0] token_pid_o,
  output logic [3:0] target_endpoint_o,
  output logic [6:0] token_addr_o,
  output logic token_pingpong_o,
  output logic slow_rate_o,
  output logic [7:0] payload_bytes_o,
  output logic eye_test_enable_o,
  output logic drive_window_n_o,
  output logic bus_power_pullup_o,
  output logic external_ctrl_serial_o,
  output logic onchip_comparator_off_o,
  output logic onchip_transceiver_off_o,
  output logic [2:0] session_status_o
);
  localparam logic [`UHC_TOK_W-1:0] TOK_LOAD = `UHC_TOK_W'(`UHC_TOK_CYC);
  localparam logic [`UHC_TOK_W-1:0] TOK_ONE = `UHC_TOK_W'(1);

  // ping-pong decision for one endpoint and direction
  function automatic logic pp_on(input logic [1:0] m, input logic [3:0] ep,
                                 input logic is_out);
    pp_on = (m == `UHC_PP_ALL) || ((m == `UHC_PP_EP1UP) && (ep != 4'h0)) ||
            ((m == `UHC_PP_EP0OUT) && (ep == 4'h0) && is_out);
  endfunction

  // threshold in cycles: count covers overhead and payload bytes
  function automatic logic [`UHC_NEED_W-1:0] need_cyc(
      input logic [7:0] cnt, input logic slow);
    need_cyc = `UHC_NEED_W'(cnt) * (slow ? `UHC_NEED_W'(`UHC_LS_BYTE_CYC) :
                                           `UHC_NEED_W'(`UHC_FS_BYTE_CYC));
  endfunction

  // reset release through two flops
  logic [1:0] rst_sync_ff;
  wire rst_n = rst_sync_ff[1];
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) rst_sync_ff <= 2'h0;
    else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  // pin synchronisers, first stage only feeds the second
  logic [9:0] pin_meta_ff;
  logic [9:0] pin_ff;
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_ff <= 10'h000;
      pin_ff <= 10'h000;
    end else begin
      pin_meta_ff <= {onchip_cmp_i, comparator_status_pin_b_i,
                      comparator_status_pin_a_i, session_end_pin_i,
                      session_valid_pin_i, bus_power_valid_pin_i, dm_i, dp_i};
      pin_ff <= pin_meta_ff;
    end
  end

  // register file, low byte of each word
  logic [7:0] ctrl_ff; // host_control, writable bits 4:0
  logic [7:0] addr_ff; // device_address
  logic [7:0] tok_ff; // token_command
  logic [7:0] sof_ff; // frame_threshold
  logic [7:0] cfg1_ff; // config_one
  logic [7:0] cfg2_ff; // config_two
  logic [7:0] pwr_ff; // power_control

  // axi channel state
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic [7:0] awaddr_ff;
  logic [7:0] wdata_ff;
  logic wstrb_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [7:0] rdata_ff;

  // token sequencer
  uhc_tok_state_t tok_state_ff;
  uhc_tok_state_t nxt_tok_state;
  logic [`UHC_TOK_W-1:0] tok_cnt_ff;
  logic start_ff;

  // mode decode
  wire pwr_on = pwr_ff[`UHC_B_PWR];
  wire run = pwr_on & ~(cfg1_ff[`UHC_B_SIDL] & cpu_idle_i);
  wire host = run & ctrl_ff[`UHC_B_HOST];
  wire slow = host & addr_ff[`UHC_B_SLOW];
  wire sof_run = host & ctrl_ff[`UHC_B_FRAME_MARKER_ENABLE];

  // live line flags; j polarity flips with speed
  wire se0 = run & ~pin_ff[0] & ~pin_ff[1];
  wire j_lvl = run & (slow ? (~pin_ff[0] & pin_ff[1]) :
                             (pin_ff[0] & ~pin_ff[1]));
  wire busy = tok_state_ff != UHC_T_IDLE;

  // frame timer
  uhc_frame_if frm();
  assign frm.run = sof_run;
  uhc_frame_timer #(.FRAME_CYC(FRAME_CYC)) u_frame (
    .clk_i(mclk_i),
    .rst_n_i(rst_n),
    .frm(frm)
  );

  // write decode
  wire wr_go = ~awready_ff & ~wready_ff & ~bvalid_ff;
  wire wr_en = wr_go & wstrb_ff;
  wire wr_map = (awaddr_ff == `UHC_A_CTRL) | (awaddr_ff == `UHC_A_ADDR) |
                (awaddr_ff == `UHC_A_TOK) | (awaddr_ff == `UHC_A_SOF) |
                (awaddr_ff == `UHC_A_CFG1) | (awaddr_ff == `UHC_A_CFG2) |
                (awaddr_ff == `UHC_A_PWR);
  wire wr_tok = wr_en & (awaddr_ff == `UHC_A_TOK);
  wire [7:0] lock = pwr_on ? `UHC_CFG2_LOCK : 8'h00;
  wire pid_ok = (wdata_ff[7:4] == `UHC_PID_SETUP) |
                (wdata_ff[7:4] == `UHC_PID_IN) |
                (wdata_ff[7:4] == `UHC_PID_OUT);

  // read decode; upper bits and reserved bits read zero
  wire [7:0] ctrl_rd = {j_lvl, se0, busy, ctrl_ff[4:0]};
  wire [7:0] addr_rd = {addr_ff[7] & ctrl_ff[`UHC_B_HOST], addr_ff[6:0]};
  wire [7:0] rd_val =
    (s_axi_araddr_i == `UHC_A_CTRL) ? ctrl_rd :
    (s_axi_araddr_i == `UHC_A_ADDR) ? addr_rd :
    (s_axi_araddr_i == `UHC_A_TOK) ? tok_ff :
    (s_axi_araddr_i == `UHC_A_SOF) ? sof_ff :
    (s_axi_araddr_i == `UHC_A_CFG1) ? cfg1_ff :
    (s_axi_araddr_i == `UHC_A_CFG2) ? cfg2_ff :
    (s_axi_araddr_i == `UHC_A_PWR) ? pwr_ff : 8'h00;
  wire rd_map = (s_axi_araddr_i == `UHC_A_CTRL) |
                (s_axi_araddr_i == `UHC_A_ADDR) |
                (s_axi_araddr_i == `UHC_A_TOK) |
                (s_axi_araddr_i == `UHC_A_SOF) |
                (s_axi_araddr_i == `UHC_A_CFG1) |
                (s_axi_araddr_i == `UHC_A_CFG2) |
                (s_axi_araddr_i == `UHC_A_PWR);

  // axi write channels: address and data taken in either order
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 8'h00;
      wstrb_ff <= 1'b0;
    end else begin
      if (awready_ff && s_axi_awvalid_i) begin
        awready_ff <= 1'b0;
        awaddr_ff <= s_axi_awaddr_i;
      end
      if (wready_ff && s_axi_wvalid_i) begin
        wready_ff <= 1'b0;
        wdata_ff <= s_axi_wdata_i[7:0];
        wstrb_ff <= s_axi_wstrb_i[0];
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_map ? 2'h0 : 2'h2; // slverr on a hole
      end else if (bvalid_ff && s_axi_bready_i) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // axi read channel: data latched at the address handshake
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'h0;
      rdata_ff <= 8'h00;
    end else if (arready_ff && s_axi_arvalid_i) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_val;
      rresp_ff <= rd_map ? 2'h0 : 2'h2;
    end else if (rvalid_ff && s_axi_rready_i) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // register writes; masks keep reserved bits at zero
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= 8'h00;
      addr_ff <= 8'h00;
      tok_ff <= 8'h00;
      sof_ff <= 8'h00;
      cfg1_ff <= 8'h00;
      cfg2_ff <= 8'h00;
      pwr_ff <= 8'h00;
    end else if (wr_en) begin
      case (awaddr_ff)
        `UHC_A_CTRL: ctrl_ff <= wdata_ff & `UHC_M_CTRL;
        `UHC_A_ADDR: addr_ff <= wdata_ff & `UHC_M_ALL;
        `UHC_A_TOK: tok_ff <= wdata_ff & `UHC_M_ALL;
        `UHC_A_SOF: sof_ff <= wdata_ff & `UHC_M_ALL;
        `UHC_A_CFG1: cfg1_ff <= wdata_ff & `UHC_M_CFG1;
        // disables frozen while powered; the rest still writes
        `UHC_A_CFG2: cfg2_ff <= (wdata_ff & `UHC_M_CFG2 & ~lock) |
                                (cfg2_ff & lock);
        `UHC_A_PWR: pwr_ff <= wdata_ff & `UHC_M_PWR;
        default: ;
      endcase
    end
  end

  // token sequencer next state: wait for room before the next frame
  wire [`UHC_NEED_W-1:0] left_ext = `UHC_NEED_W'(frm.left);
  wire room = ~sof_run | (left_ext > need_cyc(sof_ff, slow));
  wire tok_done = tok_cnt_ff == TOK_ONE;
  always_comb begin
    nxt_tok_state = tok_state_ff;
    case (tok_state_ff)
      UHC_T_IDLE: if (wr_tok && pid_ok && host) nxt_tok_state = UHC_T_WAIT;
      UHC_T_WAIT: begin
        if (!host) nxt_tok_state = UHC_T_IDLE;
        else if (room && !frm.tick) nxt_tok_state = UHC_T_BUSY;
      end
      UHC_T_BUSY: begin
        if (!host || tok_done) nxt_tok_state = UHC_T_IDLE;
      end
      default: nxt_tok_state = UHC_T_IDLE;
    endcase
  end

  // token sequencer registers; length of a token is a fixed budget
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tok_state_ff <= UHC_T_IDLE;
      tok_cnt_ff <= TOK_LOAD;
      start_ff <= 1'b0;
    end else begin
      tok_state_ff <= nxt_tok_state;
      start_ff <= (tok_state_ff == UHC_T_WAIT) &&
                  (nxt_tok_state == UHC_T_BUSY);
      if (tok_state_ff == UHC_T_BUSY) tok_cnt_ff <= tok_cnt_ff - TOK_ONE;
      else tok_cnt_ff <= TOK_LOAD;
    end
  end

  // registered outputs
  logic [7:0] o_ctl_ff; // run, host, pulldown, rst, resume, ppclr, sof
  logic [17:0] o_tok_ff; // start, pid, ep, addr, pp, slow
  logic [7:0] o_pay_ff;
  logic [6:0] o_cfg_ff; // eye, oe_n, pu, ser, cmpoff, xoff
  logic [1:0] o_pp_ff;
  logic [2:0] o_sess_ff;

  // drive window covers every interval the host drives the lines
  wire driving = (tok_state_ff == UHC_T_BUSY) | frm.tick |
                 (host & (ctrl_ff[`UHC_B_RST] | ctrl_ff[`UHC_B_RESUME]));
  wire xoff = cfg2_ff[`UHC_B_XOFF];
  wire oe_n = ~(run & cfg1_ff[`UHC_B_OEMON] & xoff & driving);
  // three-pin or two-pin interface, used only with the comparator off
  wire [2:0] ext_sess = cfg2_ff[`UHC_B_SEL] ?
                        {pin_ff[2], pin_ff[3], pin_ff[4]} :
                        {pin_ff[6], pin_ff[5], 1'b0};
  wire [2:0] sess = cfg2_ff[`UHC_B_CMPOFF] ? ext_sess : pin_ff[9:7];
  wire [7:0] pay = sof_ff - `UHC_SOF_OVH;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      o_ctl_ff <= 8'h00;
      o_tok_ff <= 18'h00000;
      o_pay_ff <= 8'h00;
      o_cfg_ff <= 7'h20; // only the active-low monitor idles high
      o_pp_ff <= 2'h0;
      o_sess_ff <= 3'h0;
    end else begin
      o_ctl_ff <= {1'b0, run, host, host,
                   host & ctrl_ff[`UHC_B_RST],
                   host & ctrl_ff[`UHC_B_RESUME],
                   run & ctrl_ff[`UHC_B_PPCLR],
                   frm.tick};
      o_tok_ff <= {start_ff, tok_ff[7:4], tok_ff[3:0], addr_ff[6:0],
                   pp_on(cfg1_ff[1:0], tok_ff[3:0],
                         tok_ff[7:4] != `UHC_PID_IN),
                   slow};
      o_pay_ff <= pay;
      o_cfg_ff <= {run & cfg1_ff[`UHC_B_EYE], oe_n,
                   run & cfg2_ff[`UHC_B_PU],
                   cfg2_ff[`UHC_B_SER],
                   cfg2_ff[`UHC_B_CMPOFF], xoff, 1'b0};
      o_pp_ff <= cfg1_ff[1:0];
      o_sess_ff <= sess;
    end
  end

  assign s_axi_awready_o = awready_ff;
  assign s_axi_wready_o = wready_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_arready_o = arready_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rresp_o = rresp_ff;
  assign s_axi_rdata_o = {24'h000000, rdata_ff};
  assign module_run_o = o_ctl_ff[6];
  assign host_mode_o = o_ctl_ff[5];
  assign line_pulldown_o = o_ctl_ff[4];
  assign bus_reset_drive_o = o_ctl_ff[3];
  assign resume_drive_o = o_ctl_ff[2];
  assign pingpong_pointer_clear_o = o_ctl_ff[1];
  assign frame_marker_o = o_ctl_ff[0];
  assign token_start_o = o_tok_ff[17];
  assign token_pid_o = o_tok_ff[16:13];
  assign target_endpoint_o = o_tok_ff[12:9];
  assign token_addr_o = o_tok_ff[8:2];
  assign token_pingpong_o = o_tok_ff[1];
  assign slow_rate_o = o_tok_ff[0];
  assign payload_bytes_o = o_pay_ff;
  assign eye_test_enable_o = o_cfg_ff[6];
  assign drive_window_n_o = o_cfg_ff[5];
  assign bus_power_pullup_o = o_cfg_ff[4];
  assign external_ctrl_serial_o = o_cfg_ff[3];
  assign onchip_comparator_off_o = o_cfg_ff[2];
  assign onchip_transceiver_off_o = o_cfg_ff[1];
  assign pingpong_config_o = o_pp_ff;
  assign session_status_o = o_sess_ff;
endmodule
`default_nettype wire

//--- core/uhc_defs.svh
/*
  constants for the usb host control and configuration block.
  assumes 100 MHz mclk_i and an axi4-lite register bus, 8-bit address.
*/
// Functional notes
// - live j-level and se0 flags, read only
// - token busy high while token executes
// - reset bit drives bus reset; software times
// - host enable switches on both pull-downs
// - resume bit drives resume; software holds 10ms
// - pointer clear returns ping-pong to even bank
// - frame marker sent every millisecond when enabled
// - slow rate bit host only, reads zero otherwise
// - seven-bit device address, reset zero
// - token type setup, in, out; others reserved
// - threshold count is ten plus payload bytes
// - eye test bit enables eye pattern test
// - drive window monitor only when transceiver off
// - halt in idle stops module in cpu idle
// - ping-pong config selects even/odd buffering
// - comparator pin select picks three or two pins
// - bus power pull-up follows its enable bit
// - external control over serial or dedicated pins
// - comparator off takes session from digital pins
// - transceiver off routes traffic digitally
// - power enable is master switch for module
`ifndef UHC_DEFS_SVH
`define UHC_DEFS_SVH

// register byte offsets
`define UHC_A_CTRL 8'h00
`define UHC_A_ADDR 8'h04
`define UHC_A_TOK 8'h08
`define UHC_A_SOF 8'h0c
`define UHC_A_CFG1 8'h10
`define UHC_A_CFG2 8'h14
`define UHC_A_PWR 8'h18

// writable bits per register
`define UHC_M_CTRL 8'h1f
`define UHC_M_ALL 8'hff
`define UHC_M_CFG1 8'hd3
`define UHC_M_CFG2 8'h3b
`define UHC_M_PWR 8'h01
`define UHC_CFG2_LOCK 8'h03

// field positions
`define UHC_B_RST 4
`define UHC_B_HOST 3
`define UHC_B_RESUME 2
`define UHC_B_PPCLR 1
`define UHC_B_FRAME_MARKER_ENABLE 0
`define UHC_B_SLOW 7
`define UHC_B_EYE 7
`define UHC_B_OEMON 6
`define UHC_B_SIDL 4
`define UHC_B_SEL 5
`define UHC_B_PU 4
`define UHC_B_SER 3
`define UHC_B_CMPOFF 1
`define UHC_B_XOFF 0
`define UHC_B_PWR 0

// token type codes
`define UHC_PID_SETUP 4'hd
`define UHC_PID_IN 4'h9
`define UHC_PID_OUT 4'h1

// ping-pong modes
`define UHC_PP_EP1UP 2'h3
`define UHC_PP_ALL 2'h2
`define UHC_PP_EP0OUT 2'h1

// frame overhead in bytes
`define UHC_SOF_OVH 8'h0a

// times in ns and derived cycle counts
`define UHC_CLK_NS 10
`define UHC_FRAME_NS 1000000
`define UHC_FRAME_CYC (`UHC_FRAME_NS / `UHC_CLK_NS)
`define UHC_FRAME_W 17
`define UHC_FS_BYTE_NS 667
`define UHC_LS_BYTE_NS 5334
`define UHC_FS_BYTE_CYC ((`UHC_FS_BYTE_NS + `UHC_CLK_NS - 1) / `UHC_CLK_NS)
`define UHC_LS_BYTE_CYC ((`UHC_LS_BYTE_NS + `UHC_CLK_NS - 1) / `UHC_CLK_NS)
`define UHC_TOK_NS 2000
`define UHC_TOK_CYC ((`UHC_TOK_NS + `UHC_CLK_NS - 1) / `UHC_CLK_NS)
`define UHC_TOK_W 8
`define UHC_NEED_W 18

`endif

//--- core/uhc_pkg.sv
/*
  types for the usb host control block.
  assumes uhc_defs.svh is compiled alongside.
*/
package uhc_pkg;
  // token sequencer states
  typedef enum logic [1:0] {
    UHC_T_IDLE,
    UHC_T_WAIT,
    UHC_T_BUSY
  } uhc_tok_state_t;
endpackage

//--- core/uhc_frame_if.sv
/*
  frame timer carrier between the control block and its frame timer.
  assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uhc_defs.svh"
interface uhc_frame_if;
  logic run; // timer counts while high
  logic tick; // one-cycle pulse per frame
  logic [`UHC_FRAME_W-1:0] left; // cycles left in frame
  modport timer(input run, output tick, output left);
  modport user(output run, input tick, input left);
endinterface
`default_nettype wire

//--- core/uhc_frame_timer.sv
/*
  millisecond frame timer: down-counter giving a frame pulse and time left.
  assumes run comes from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uhc_defs.svh"
module uhc_frame_timer #(
  parameter int FRAME_CYC = `UHC_FRAME_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  uhc_frame_if.timer frm
);
  localparam logic [`UHC_FRAME_W-1:0] LOAD = `UHC_FRAME_W'(FRAME_CYC);
  localparam logic [`UHC_FRAME_W-1:0] ONE = `UHC_FRAME_W'(1);

  logic [`UHC_FRAME_W-1:0] cnt_ff; // cycles left
  logic tick_ff; // frame pulse
  wire wrap = frm.run & (cnt_ff == ONE);

  // reload while stopped so a fresh frame starts full length
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= LOAD;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= (!frm.run || wrap) ? LOAD : cnt_ff - ONE;
      tick_ff <= wrap;
    end
  end

  assign frm.tick = tick_ff;
  assign frm.left = cnt_ff;
endmodule
`default_nettype wire

//--- verification/uhc_line_partner.sv
/*
  attached usb device as seen on the data lines.
  assumes the bench picks the line state after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module uhc_line_partner (
  input wire logic [1:0] state_i, // 0 j, 1 k, 2 se0, 3 detached
  input wire logic slow_i, // low speed device
  output logic dp_o,
  output logic dm_o
);
  // j polarity flips with speed; detached lines sit on host pull-downs
  always_comb begin
    case (state_i)
      2'd0: {dp_o, dm_o} = slow_i ? 2'b01 : 2'b10;
      2'd1: {dp_o, dm_o} = slow_i ? 2'b10 : 2'b01;
      default: {dp_o, dm_o} = 2'b00;
    endcase
  end
endmodule
`default_nettype wire

//--- verification/uhc_host_ctrl_props.sv
/*
  port assertions for the host control block.
  assumes a bind onto uhc_host_ctrl, one clock, async low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module uhc_host_ctrl_props (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic module_run_o,
  input wire logic host_mode_o,
  input wire logic line_pulldown_o,
  input wire logic bus_reset_drive_o,
  input wire logic resume_drive_o,
  input wire logic frame_marker_o,
  input wire logic token_start_o,
  input wire logic [3:0] token_pid_o,
  input wire logic eye_test_enable_o,
  input wire logic drive_window_n_o,
  input wire logic onchip_transceiver_off_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  property p_pd; host_mode_o == line_pulldown_o; endproperty
  a_pd: assert property (p_pd) else $error("pulldown mismatch");
  property p_rst; bus_reset_drive_o |-> host_mode_o; endproperty
  a_rst: assert property (p_rst) else $error("reset off host");
  property p_res; resume_drive_o |-> host_mode_o; endproperty
  a_res: assert property (p_res) else $error("resume off host");
  property p_sof; frame_marker_o |=> !frame_marker_o [*8]; endproperty
  a_sof: assert property (p_sof) else $error("frame too soon");
  property p_pid; token_start_o |-> token_pid_o inside {4'hd, 4'h9, 4'h1};
  endproperty
  a_pid: assert property (p_pid) else $error("reserved pid");
  property p_tok; token_start_o |-> host_mode_o; endproperty
  a_tok: assert property (p_tok) else $error("token off host");
  property p_oe; !drive_window_n_o |-> onchip_transceiver_off_o; endproperty
  a_oe: assert property (p_oe) else $error("monitor w/ xcvr");
  // run output updates on the same edge as the outputs it gates
  property p_eye; eye_test_enable_o |-> module_run_o || $past(module_run_o);
  endproperty
  a_eye: assert property (p_eye) else $error("eye w/o run");
  property p_run; !module_run_o && !$past(module_run_o) |-> !host_mode_o;
  endproperty
  a_run: assert property (p_run) else $error("host w/o run");
endmodule
bind uhc_host_ctrl uhc_host_ctrl_props uhc_host_ctrl_props_i (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .module_run_o(module_run_o),
  .host_mode_o(host_mode_o), .line_pulldown_o(line_pulldown_o),
  .bus_reset_drive_o(bus_reset_drive_o), .resume_drive_o(resume_drive_o),
  .frame_marker_o(frame_marker_o), .token_start_o(token_start_o),
  .token_pid_o(token_pid_o), .eye_test_enable_o(eye_test_enable_o),
  .drive_window_n_o(drive_window_n_o),
  .onchip_transceiver_off_o(onchip_transceiver_off_o));
`default_nettype wire

//--- verification/uhc_host_ctrl_tb_top.sv
/*
  self-checking bench: axi4-lite master, register mirror, line partner.
  assumes FRAME_CYC shortened to 400 cycles and a 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module uhc_host_ctrl_tb_top;
  localparam int FRM = 400; // short frame
  localparam logic [7:0] MSK [7] = '{8'h1f, 8'hff, 8'hff, 8'hff, 8'hd3,
    8'h3b, 8'h01}; // writable bits
  logic mclk_i = 0, nrst_i = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic idle = 0, sl = 0;
  logic [7:0] aw = 0, ar = 0, e, v;
  logic [31:0] wd = 0, rdat;
  logic [1:0] ln = 0, ab = 0, br, rr, ppcfg;
  logic [2:0] tp = 0, oc = 0, ss;
  logic [3:0] tpid, tep;
  logic [6:0] tad;
  logic [7:0] pay, m [7]; // mirror of stored register bits
  logic awr, wrdy, bv, arr, rv, dp, dm, run, host, pd, brst, resd, ppc;
  logic fm, ts, slow, eye, dwn, pu, ser, offc, offx;
  int num_errors = 0, total_checks = 0, n, c, cyc = 0;
  initial forever #5 mclk_i = ~mclk_i;
  uhc_line_partner uhc_line_partner_i (.state_i(ln), .slow_i(sl),
    .dp_o(dp), .dm_o(dm));
  uhc_host_ctrl #(.FRAME_CYC(FRM)) uhc_host_ctrl_i (.mclk_i(mclk_i),
    .nrst_i(nrst_i), .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(br),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_araddr_i(ar),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdat),
    .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
    .dp_i(dp), .dm_i(dm), .bus_power_valid_pin_i(tp[2]),
    .session_valid_pin_i(tp[1]), .session_end_pin_i(tp[0]),
    .comparator_status_pin_a_i(ab[0]), .comparator_status_pin_b_i(ab[1]),
    .onchip_cmp_i(oc), .cpu_idle_i(idle), .module_run_o(run),
    .host_mode_o(host), .line_pulldown_o(pd), .bus_reset_drive_o(brst),
    .resume_drive_o(resd), .pingpong_pointer_clear_o(ppc),
    .pingpong_config_o(ppcfg), .frame_marker_o(fm), .token_start_o(ts),
    .token_pid_o(tpid), .target_endpoint_o(tep), .token_addr_o(tad),
    .token_pingpong_o(), .slow_rate_o(slow), .payload_bytes_o(pay),
    .eye_test_enable_o(eye), .drive_window_n_o(dwn),
    .bus_power_pullup_o(pu), .external_ctrl_serial_o(ser),
    .onchip_comparator_off_o(offc), .onchip_transceiver_off_o(offx),
    .session_status_o(ss));
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] y);
    total_checks++;
    if (x !== y) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h seen %h", s, y, x);
    end
  endtask
  task automatic w(input int k);
    repeat (k) @(posedge mclk_i);
  endtask
  // write one register index; mirror keeps locked config_two bits
  task automatic wr(input int i, input logic [7:0] d);
    @(posedge mclk_i);
    aw <= 8'(i * 4); wd <= {24'h0, d}; awv <= 1; wv <= 1; bre <= 1;
    do begin
      @(posedge mclk_i);
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
    end while (!bv);
    bre <= 0;
    chk("bresp", br, i < 7 ? 0 : 2);
    if (i < 7) begin
      v = d & MSK[i];
      if (i == 5 && m[6][0]) v[1:0] = m[5][1:0];
      m[i] = v;
    end
  endtask
  // read one index; live adds the hardware-set bits expected
  task automatic rd(input int i, input logic [7:0] live);
    @(posedge mclk_i);
    ar <= 8'(i * 4); arv <= 1; rre <= 1;
    do begin
      @(posedge mclk_i);
      if (arr) arv <= 0;
    end while (!rv);
    rre <= 0;
    e = i < 7 ? m[i] : 8'h00;
    if (i == 1 && !m[0][3]) e[7] = 0;
    chk("rdata", rdat, {24'h0, e | live});
    chk("rresp", rr, i < 7 ? 0 : 2);
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, far above the planned run
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      close_out;
    end
  end
  initial begin
    n = $urandom(7945);
    for (int i = 0; i < 7; i++) m[i] = 0;
    w(4);
    nrst_i <= 1;
    w(4);
    for (int i = 0; i < 8; i++) rd(i, 0);
    chk("oe_n", dwn, 1);
    wr(6, 1); w(4); chk("run", run, 1);
    wr(0, 8'h0d); w(4); rd(0, 8'h80);
    chk("ctl", {host, pd, resd, brst}, 4'he);
    ln <= 2; w(4); rd(0, 8'h40);
    n = 0;
    while (!fm && n < 2 * FRM) begin w(1); n++; end
    n = 0;
    do begin w(1); n++; end while (!fm && n < 2 * FRM);
    chk("frame", n, FRM);
    wr(0, 8'h1a); w(2); chk("rst", {brst, ppc, resd}, 3'b110);
    wr(0, 8'h08); w(2); chk("clr", {brst, ppc}, 0);
    n = 0;
    repeat (2 * FRM) begin w(1); n += fm; end
    chk("nosof", n, 0);
    c = $urandom; ln <= 0;
    wr(1, 8'(c) | 8'h80); rd(1, 0); sl <= 1; w(4);
    chk("slow", {slow, tad}, {1'b1, 7'(c)});
    rd(0, 8'h80); sl <= 0; wr(1, 8'(c) & 8'h7f);
    wr(3, 8'h4a); w(2); chk("pay", pay, 64);
    c = 10 + $urandom % 246;
    wr(3, 8'(c)); w(2); chk("pay", pay, c - 10);
    wr(3, 0); wr(0, 8'h09);
    foreach (MSK[k]) if (k < 4) begin
      v = {k == 3 ? 4'h5 : k == 2 ? 4'h1 : k == 1 ? 4'h9 : 4'hd, 4'($urandom)};
      // count at once: the start pulse follows the write within a few edges
      wr(2, v);
      n = 0;
      repeat (2 * FRM) begin w(1); n += ts; if (ts) e = {tpid, tep}; end
      chk("starts", n, k < 3);
      if (k < 3) chk("tok", e, v);
      rd(2, 0);
      rd(0, 8'h88 | 8'h01);
    end
    wr(2, 8'h15); rd(0, 8'ha9);
    w(2 * FRM);
    for (int p = 0; p < 4; p++) begin
      wr(4, {p[1], 1'b1, 4'h0, 2'(p)}); rd(4, 0); w(2);
      chk("pp", {eye, ppcfg}, {p[1], 2'(p)});
    end
    for (int h = 0; h < 2; h++) begin
      wr(4, h ? 8'h10 : 8'h00); idle <= 1; w(4);
      chk("idle", run, !h);
      idle <= 0; w(4);
    end
    wr(5, 8'h3b); rd(5, 0); w(2);
    chk("cfg2", {pu, ser, offc, offx}, 4'hc);
    wr(0, 0); wr(6, 0); wr(5, 8'h3b); rd(5, 0); wr(6, 1); w(2);
    chk("off", {offc, offx}, 2'b11);
    tp <= 3'($urandom); oc <= 3'($urandom); w(4);
    chk("sess3", ss, tp);
    wr(5, 8'h1b); ab <= 2'($urandom); w(4);
    chk("sess2", ss, {ab[1], ab[0], 1'b0});
    close_out;
  end
endmodule
`default_nettype wire
